// *** hw/fle_exec.sv ***
// Flag, move and data-memory load/store execution core
`default_nettype none
`include "fle_defines.svh"
module fle_exec
  import fle_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire fle_instr_t  instr_in,
  input  wire logic        instr_valid_in,
  output logic             instr_ready_out,
  output fle_mem_req_t     mem_req_out,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [7:0]  status_out,
  output logic             busy_out,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic      [1:0]  s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic      [31:0] s_axi_rdata_out,
  output logic      [1:0]  s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);
  fle_state_t   state_reg;
  fle_instr_t   held_reg;
  logic [7:0]   status_word_reg;
  logic [7:0]   status_word_next;
  logic         accept;
  logic [15:0]  ptr_val;
  logic [15:0]  ptr_cur;
  logic [15:0]  ptr_new;
  logic [15:0]  ea;
  logic [4:0]   ptr_lo;
  logic         ptr_upd;
  logic         wa_en;
  logic [4:0]   wa_idx;
  logic [7:0]   wa_data;
  logic         wb_en;
  logic [4:0]   wb_idx;
  logic [7:0]   wb_data;
  logic         pa_en;
  logic [7:0]   rr_data;
  logic [7:0]   rs_data;
  logic [15:0]  ptr_x;
  logic [15:0]  ptr_y;
  logic [15:0]  ptr_z;
  logic         irq_set;
  logic         irq_clr;
  logic         is_mem;
  logic         is_write;

  // ==========================================================
  // Issue control: memory ops hold the core for a second cycle
  assign busy_out        = (state_reg == FLE_ST_MEM);
  assign instr_ready_out = (state_reg == FLE_ST_IDLE);
  assign accept          = instr_valid_in && instr_ready_out;
  assign is_mem   = instr_in.op inside {FLE_OP_PTR_LOAD, FLE_OP_OFFSET_LOAD,
                                        FLE_OP_DIRECT_LOAD, FLE_OP_PTR_WRITE,
                                        FLE_OP_DIRECT_WRITE};
  assign is_write = instr_in.op inside {FLE_OP_PTR_WRITE, FLE_OP_DIRECT_WRITE};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= FLE_ST_IDLE;
    end else begin
      case (state_reg)
        FLE_ST_IDLE: if (accept && is_mem) begin
          state_reg <= FLE_ST_MEM;
        end
        FLE_ST_MEM:  state_reg <= FLE_ST_IDLE;
        default:     state_reg <= FLE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      held_reg <= '0;
    end else if (accept) begin
      held_reg <= instr_in;
    end
  end

  // ==========================================================
  // Pointer selection and effective address
  always_comb begin
    case (instr_in.ptr)
      FLE_PTR_X: begin ptr_cur = ptr_x; ptr_lo = `FLE_PTR_X_LO; end
      FLE_PTR_Y: begin ptr_cur = ptr_y; ptr_lo = `FLE_PTR_Y_LO; end
      FLE_PTR_Z: begin ptr_cur = ptr_z; ptr_lo = `FLE_PTR_Z_LO; end
      default:   begin ptr_cur = ptr_x; ptr_lo = `FLE_PTR_X_LO; end
    endcase
    ptr_val = ptr_cur;
    ptr_new = ptr_cur;
    ptr_upd = 1'b0;
    if (instr_in.mode == FLE_MODE_POST) begin
      ptr_new = ptr_cur + `FLE_ONE16;
      ptr_upd = 1'b1;
    end else if (instr_in.mode == FLE_MODE_PRE) begin
      ptr_new = ptr_cur - `FLE_ONE16;
      ptr_val = ptr_new;
      ptr_upd = 1'b1;
    end
    case (instr_in.op)
      FLE_OP_OFFSET_LOAD:  ea = ptr_cur + instr_in.addr;
      FLE_OP_DIRECT_LOAD,
      FLE_OP_DIRECT_WRITE: ea = instr_in.addr;
      default:             ea = ptr_val;
    endcase
  end

  // Address and store data are registered out the cycle after issue; read data returns in that same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mem_req_out <= '{re: 1'b0, we: 1'b0, addr: `FLE_ADDR_RST, wdata: `FLE_DATA_RST};
    end else if (accept && is_mem) begin
      mem_req_out.re    <= !is_write;
      mem_req_out.we    <= is_write;
      mem_req_out.addr  <= ea;
      mem_req_out.wdata <= rr_data;
    end else begin
      mem_req_out.re <= 1'b0;
      mem_req_out.we <= 1'b0;
    end
  end

  // ==========================================================
  // Register file writes
  assign pa_en = accept && (instr_in.op == FLE_OP_PAIR_COPY);

  always_comb begin
    wa_en   = 1'b0;
    wa_idx  = instr_in.rd;
    wa_data = rr_data;
    wb_en   = 1'b0;
    wb_idx  = instr_in.rd;
    wb_data = rs_data;
    if (state_reg == FLE_ST_MEM && !(held_reg.op inside {FLE_OP_PTR_WRITE,
                                                         FLE_OP_DIRECT_WRITE})) begin
      wa_en   = 1'b1;
      wa_idx  = held_reg.rd;
      wa_data = mem_rdata_in;
    end else if (accept) begin
      case (instr_in.op)
        FLE_OP_REG_COPY: begin
          wa_en = 1'b1;
        end
        FLE_OP_PAIR_COPY: begin
          wa_en   = 1'b1;
          wa_idx  = {instr_in.rd[4:1], 1'b0};
          wb_en   = 1'b1;
          wb_idx  = {instr_in.rd[4:1], 1'b1};
        end
        FLE_OP_IMM_LOAD: begin
          wa_en   = 1'b1;
          wa_data = instr_in.imm;
        end
        FLE_OP_T_TO_BIT: begin
          wa_en   = 1'b1;
          wa_data = rr_data;
          wa_data[instr_in.bsel] = status_word_reg[`FLE_BIT_T];
        end
        default: wa_en = 1'b0;
      endcase
    end
    // Pointer low byte on port A, high byte on port B; a load into the pointer lands a cycle later and wins
    if (accept && is_mem && ptr_upd && instr_in.op inside {FLE_OP_PTR_LOAD,
                                                            FLE_OP_PTR_WRITE}) begin
      wa_en   = 1'b1;
      wa_idx  = ptr_lo;
      wa_data = ptr_new[7:0];
      wb_en   = 1'b1;
      wb_idx  = ptr_lo + 5'h01;
      wb_data = ptr_new[15:8];
    end
  end

  // ==========================================================
  // Status word
  always_comb begin
    status_word_next = status_word_reg;
    if (irq_set) begin
      status_word_next[`FLE_BIT_I] = 1'b1;
    end else if (irq_clr) begin
      status_word_next[`FLE_BIT_I] = 1'b0;
    end
    if (accept) begin
      case (instr_in.op)
        FLE_OP_FLAG_SET:   status_word_next[instr_in.bsel] = 1'b1;
        FLE_OP_FLAG_CLEAR: status_word_next[instr_in.bsel] = 1'b0;
        FLE_OP_BIT_TO_T:   status_word_next[`FLE_BIT_T] = rr_data[instr_in.bsel];
        default:           status_word_next = status_word_next;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      status_word_reg <= `FLE_STATUS_WORD_RST;
    end else begin
      status_word_reg <= status_word_next;
    end
  end

  assign status_out = status_word_reg;

  // ==========================================================
  // Submodules
  fle_regfile u_regfile (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .wa_en_in    (wa_en),
    .wa_idx_in   (wa_idx),
    .wa_data_in  (wa_data),
    .wb_en_in    (wb_en),
    .wb_idx_in   (wb_idx),
    .wb_data_in  (wb_data),
    .rr_idx_in   (pa_en ? {instr_in.rr[4:1], 1'b0} : instr_in.rr),
    .rr_data_out (rr_data),
    .rs_idx_in   ({instr_in.rr[4:1], 1'b1}),
    .rs_data_out (rs_data),
    .ptr_x_out   (ptr_x),
    .ptr_y_out   (ptr_y),
    .ptr_z_out   (ptr_z)
  );

  fle_axil u_axil (
    .clk_in            (clk_in),
    .rst_b_in          (rst_b_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .status_in         (status_word_reg),
    .ptr_x_in          (ptr_x),
    .ptr_y_in          (ptr_y),
    .ptr_z_in          (ptr_z),
    .busy_in           (busy_out),
    .irq_en_set_out    (irq_set),
    .irq_en_clr_out    (irq_clr)
  );
endmodule : fle_exec
`default_nettype wire

// *** hw/fle_defines.svh ***
// Constants for the flag and load execution block
`ifndef FLE_DEFINES_SVH
`define FLE_DEFINES_SVH

// Status word bit positions
`define FLE_BIT_C      3'd0
`define FLE_BIT_Z      3'd1
`define FLE_BIT_N      3'd2
`define FLE_BIT_V      3'd3
`define FLE_BIT_S      3'd4
`define FLE_BIT_H      3'd5
`define FLE_BIT_T      3'd6
`define FLE_BIT_I      3'd7
`define FLE_STATUS_WORD_RST   8'h00
`define FLE_REG_RST    8'h00
// Pointer pair low register indices
`define FLE_PTR_X_LO   5'h1A
`define FLE_PTR_Y_LO   5'h1C
`define FLE_PTR_Z_LO   5'h1E
`define FLE_ONE16      16'h0001
`define FLE_ADDR_RST   16'h0000
`define FLE_DATA_RST   8'h00

// AXI4-Lite register map (byte addresses)
`define FLE_OFS_STATUS 12'h000
`define FLE_OFS_PTRX   12'h004
`define FLE_OFS_PTRY   12'h008
`define FLE_OFS_PTRZ   12'h00C
`define FLE_OFS_INFO   12'h010
`define FLE_RESP_OKAY  2'b00
`define FLE_RESP_SLV   2'b10

`endif

// *** hw/fle_pkg.sv ***
// Types shared by the flag and load execution block
`default_nettype none
package fle_pkg;
  typedef enum logic [4:0] {
    FLE_OP_NONE         = 5'b00000,
    FLE_OP_FLAG_SET     = 5'b00001,
    FLE_OP_FLAG_CLEAR   = 5'b00010,
    FLE_OP_BIT_TO_T     = 5'b00011,
    FLE_OP_T_TO_BIT     = 5'b00100,
    FLE_OP_REG_COPY     = 5'b00101,
    FLE_OP_PAIR_COPY    = 5'b00110,
    FLE_OP_IMM_LOAD     = 5'b00111,
    FLE_OP_PTR_LOAD     = 5'b01000,
    FLE_OP_OFFSET_LOAD  = 5'b01001,
    FLE_OP_DIRECT_LOAD  = 5'b01010,
    FLE_OP_PTR_WRITE    = 5'b01011,
    FLE_OP_DIRECT_WRITE = 5'b01100
  } fle_op_t;

  typedef enum logic [1:0] {
    FLE_PTR_X = 2'b00,
    FLE_PTR_Y = 2'b01,
    FLE_PTR_Z = 2'b10
  } fle_ptr_t;

  typedef enum logic [1:0] {
    FLE_MODE_PLAIN = 2'b00,
    FLE_MODE_POST  = 2'b01,
    FLE_MODE_PRE   = 2'b10
  } fle_mode_t;

  typedef struct packed {
    fle_op_t    op;
    fle_ptr_t   ptr;
    fle_mode_t  mode;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [7:0] imm;
    logic [15:0] addr;
  } fle_instr_t;

  typedef struct packed {
    logic        re;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fle_mem_req_t;

  typedef enum logic [1:0] {
    FLE_ST_IDLE = 2'b00,
    FLE_ST_MEM  = 2'b01
  } fle_state_t;
endpackage : fle_pkg
`default_nettype wire

// *** hw/fle_regfile.sv ***
// Working register file with two write ports and pointer read-out
`default_nettype none
`include "fle_defines.svh"
module fle_regfile
  import fle_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        wa_en_in,
  input  wire logic [4:0]  wa_idx_in,
  input  wire logic [7:0]  wa_data_in,
  input  wire logic        wb_en_in,
  input  wire logic [4:0]  wb_idx_in,
  input  wire logic [7:0]  wb_data_in,
  input  wire logic [4:0]  rr_idx_in,
  output logic      [7:0]  rr_data_out,
  input  wire logic [4:0]  rs_idx_in,
  output logic      [7:0]  rs_data_out,
  output logic      [15:0] ptr_x_out,
  output logic      [15:0] ptr_y_out,
  output logic      [15:0] ptr_z_out
);
  logic [7:0] regs_reg [0:31];

  // Port B wins on a clash; it carries the high byte of a two-byte write
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_reg
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          regs_reg[gi] <= `FLE_REG_RST;
        end else if (wb_en_in && wb_idx_in == 5'(gi)) begin
          regs_reg[gi] <= wb_data_in;
        end else if (wa_en_in && wa_idx_in == 5'(gi)) begin
          regs_reg[gi] <= wa_data_in;
        end
      end
    end
  endgenerate

  assign rr_data_out = regs_reg[rr_idx_in];
  assign rs_data_out = regs_reg[rs_idx_in];
  assign ptr_x_out   = {regs_reg[`FLE_PTR_X_LO + 5'h01], regs_reg[`FLE_PTR_X_LO]};
  assign ptr_y_out   = {regs_reg[`FLE_PTR_Y_LO + 5'h01], regs_reg[`FLE_PTR_Y_LO]};
  assign ptr_z_out   = {regs_reg[`FLE_PTR_Z_LO + 5'h01], regs_reg[`FLE_PTR_Z_LO]};
endmodule : fle_regfile
`default_nettype wire

// *** hw/fle_axil.sv ***
// AXI4-Lite view of status word and pointers; only the interrupt enable bit is writable
`default_nettype none
`include "fle_defines.svh"
module fle_axil
  import fle_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic      [1:0]  s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic      [31:0] s_axi_rdata_out,
  output logic      [1:0]  s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [7:0]  status_in,
  input  wire logic [15:0] ptr_x_in,
  input  wire logic [15:0] ptr_y_in,
  input  wire logic [15:0] ptr_z_in,
  input  wire logic        busy_in,
  output logic             irq_en_set_out,
  output logic             irq_en_clr_out
);
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [11:0] aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;

  // ==========================================================
  // Write path: only the global interrupt enable bit may be written
  assign s_axi_awready_out = !aw_got_reg && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_got_reg && !s_axi_bvalid_out;
  assign do_write          = aw_got_reg && w_got_reg && !s_axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 4'h0;
    end else if (do_write) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata_in[7:0];
        w_strb_reg <= s_axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `FLE_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= ({aw_addr_reg[11:2], 2'b00} == `FLE_OFS_STATUS) ?
                          `FLE_RESP_OKAY : `FLE_RESP_SLV;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Only bit 7 of the status word is writable
  always_comb begin
    irq_en_set_out = 1'b0;
    irq_en_clr_out = 1'b0;
    if (do_write && {aw_addr_reg[11:2], 2'b00} == `FLE_OFS_STATUS && w_strb_reg[0]) begin
      irq_en_set_out = w_data_reg[`FLE_BIT_I];
      irq_en_clr_out = !w_data_reg[`FLE_BIT_I];
    end
  end

  // ==========================================================
  // Read path
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `FLE_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= `FLE_RESP_OKAY;
      case ({s_axi_araddr_in[11:2], 2'b00})
        `FLE_OFS_STATUS: s_axi_rdata_out <= {24'h00_0000, status_in};
        `FLE_OFS_PTRX:   s_axi_rdata_out <= {16'h0000, ptr_x_in};
        `FLE_OFS_PTRY:   s_axi_rdata_out <= {16'h0000, ptr_y_in};
        `FLE_OFS_PTRZ:   s_axi_rdata_out <= {16'h0000, ptr_z_in};
        `FLE_OFS_INFO:   s_axi_rdata_out <= {31'h0000_0000, busy_in};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= `FLE_RESP_SLV;
        end
      endcase
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule : fle_axil
`default_nettype wire

// *** tb/fle_sram_model.sv ***
// Behavioural data memory that answers the execution core
`default_nettype none
module fle_sram_model
  import fle_pkg::*;
(
  input  wire logic         clk_in,
  input  wire fle_mem_req_t mem_req_in,
  output logic      [7:0]   rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] last_reg = 8'h00;

  // Idle bus shows inverted last byte, never stale data
  always_comb rdata_out = mem_req_in.re ? mem[mem_req_in.addr[7:0]] : ~last_reg;

  // Plain always: the bench also preloads the array directly
  always @(posedge clk_in) begin
    if (mem_req_in.re) last_reg <= mem[mem_req_in.addr[7:0]];
    if (mem_req_in.we) mem[mem_req_in.addr[7:0]] <= mem_req_in.wdata;
  end
endmodule : fle_sram_model
`default_nettype wire

// *** tb/fle_exec_chk.sv ***
// Concurrent checks on the ports of the execution core
`default_nettype none
module fle_exec_chk
  import fle_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_b_in,
  input wire fle_instr_t   instr_in,
  input wire logic         instr_valid_in,
  input wire logic         instr_ready_out,
  input wire fle_mem_req_t mem_req_out,
  input wire logic [7:0]   status_out,
  input wire logic         busy_out,
  input wire logic         s_axi_arvalid_in,
  input wire logic         s_axi_arready_out,
  input wire logic         s_axi_rvalid_out,
  input wire logic         s_axi_rready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic take, mem_op, st_op, keep_op;
  assign take = instr_valid_in && instr_ready_out;
  assign st_op = instr_in.op inside {FLE_OP_PTR_WRITE, FLE_OP_DIRECT_WRITE};
  assign mem_op = st_op || instr_in.op inside {FLE_OP_PTR_LOAD, FLE_OP_OFFSET_LOAD,
                                                FLE_OP_DIRECT_LOAD};
  assign keep_op = instr_in.op inside {FLE_OP_T_TO_BIT, FLE_OP_REG_COPY, FLE_OP_PAIR_COPY,
                                       FLE_OP_IMM_LOAD};

  // ==========================================================
  // Instruction timing and flags
  property p_mem_two;
    take && mem_op |=> (mem_req_out.re || mem_req_out.we) && busy_out && !instr_ready_out
      ##1 instr_ready_out;
  endproperty
  a_mem_two: assert property (p_mem_two)
    else $error("memory op not two cycles");
  property p_store_we;
    take && st_op |=> mem_req_out.we && !mem_req_out.re;
  endproperty
  a_store_we: assert property (p_store_we)
    else $error("store without write strobe");
  property p_pulse;
    mem_req_out.re || mem_req_out.we |=> !mem_req_out.re && !mem_req_out.we;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("memory strobe longer than one cycle");
  property p_set;
    take && instr_in.op == FLE_OP_FLAG_SET
      |=> status_out == ($past(status_out) | (8'h01 << $past(instr_in.bsel)));
  endproperty
  a_set: assert property (p_set)
    else $error("flag set wrong");
  property p_clr;
    take && instr_in.op == FLE_OP_FLAG_CLEAR
      |=> status_out == ($past(status_out) & ~(8'h01 << $past(instr_in.bsel)));
  endproperty
  a_clr: assert property (p_clr)
    else $error("flag clear wrong");
  property p_bit_t;
    take && instr_in.op == FLE_OP_BIT_TO_T
      |=> (status_out & 8'hBF) == ($past(status_out) & 8'hBF);
  endproperty
  a_bit_t: assert property (p_bit_t)
    else $error("bit store touched other flags");
  property p_keep;
    take && keep_op |=> $stable(status_out);
  endproperty
  a_keep: assert property (p_keep)
    else $error("move changed flags");
  property p_mem_flags;
    take && mem_op |=> $stable(status_out) [*2];
  endproperty
  a_mem_flags: assert property (p_mem_flags)
    else $error("memory op changed flags");
  property p_busy;
    busy_out |-> !instr_ready_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready while busy");

  // ==========================================================
  // Register bus read answer
  property p_rd;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out
      ##0 (s_axi_rready_in or ##1 s_axi_rvalid_out);
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer late or dropped");
endmodule : fle_exec_chk

bind fle_exec fle_exec_chk u_fle_exec_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .instr_in(instr_in),
  .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
  .mem_req_out(mem_req_out), .status_out(status_out), .busy_out(busy_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in));
`default_nettype wire

// *** tb/fle_exec_bench.sv ***
// Self-checking bench for the flag and load execution core
`default_nettype none
module fle_exec_bench
  import fle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_in = 1'b0;
  logic         rst_b_in = 1'b0;
  fle_instr_t   instr = '0;
  logic         valid = 1'b0;
  logic         rdy, busy, awready, wready, bvalid, arready, rvalid;
  fle_mem_req_t mem_req;
  logic [7:0]   rdata, status;
  logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]  wdata = 32'h0, axi_rdata;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]   bresp, rresp;
  int           fail_count = 0, num_checks = 0;

  always #12.5 clk_in = ~clk_in;

  fle_exec u_fle_exec (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .instr_in(instr), .instr_valid_in(valid),
    .instr_ready_out(rdy), .mem_req_out(mem_req), .mem_rdata_in(rdata),
    .status_out(status), .busy_out(busy), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(axi_rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));
  fle_sram_model u_sram (.clk_in(clk_in), .mem_req_in(mem_req), .rdata_out(rdata));

  // ==========================================================
  // Shared drivers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Call after an edge; returns at the edge that takes the op
  task automatic ex(input fle_op_t o, input logic [4:0] rd, input logic [4:0] rr = 5'h00,
                    input logic [15:0] a = 16'h0000, input logic [2:0] b = 3'h0,
                    input fle_ptr_t p = FLE_PTR_X, input fle_mode_t m = FLE_MODE_PLAIN);
    instr <= '{o, p, m, rd, rr, b, a[7:0], a};
    valid <= 1'b1;
    #1;
    while (rdy !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    @(posedge clk_in);
  endtask : ex

  task automatic fl(input fle_op_t o, input logic [2:0] b);
    ex(o, 5'h00, 5'h00, 16'h0000, b);
  endtask : fl

  task automatic settle();
    valid <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : settle

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_in); while (arready !== 1'b1);
    @(posedge clk_in);
    arvalid <= 1'b0;
    do @(negedge clk_in); while (rvalid !== 1'b1);
    d = axi_rdata;
    r = rresp;
    @(posedge clk_in);
    rready <= 1'b0;
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_in);
      ta = awvalid && awready === 1'b1;
      tw = wvalid && wready === 1'b1;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(negedge clk_in); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk_in);
    bready <= 1'b0;
  endtask : wr

  // ==========================================================
  // Scenarios
  task automatic t_flags();
    logic [7:0]  exp = 8'hFF;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) fl(FLE_OP_FLAG_SET, 3'(i));
    settle();
    chk(status, 8'hFF, "flag sets");
    for (int i = 0; i < 8; i++) begin
      fl(FLE_OP_FLAG_CLEAR, 3'(i));
      settle();
      exp[i] = 1'b0;
      chk(status, exp, "flag clear");
    end
    wr(12'h000, 32'h0000_0080, r);
    chk(r, 2'b00, "write resp");
    rd(12'h000, d, r);
    chk(d[7:0], 8'h80, "bus irq enable");
    rd(12'h020, d, r);
    chk(r, 2'b10, "unmapped resp");
    chk(d[15:0], 16'h0000, "unmapped data");
    fl(FLE_OP_FLAG_CLEAR, 3'h7);
    settle();
    chk(status, 8'h00, "interrupt disable");
    $display("test flags done");
  endtask : t_flags

  task automatic t_bits();
    logic [4:0] src [4] = '{5'h11, 5'h12, 5'h14, 5'h15};
    logic [7:0] exp [4] = '{8'h08, 8'hA5, 8'hA5, 8'h08};
    ex(FLE_OP_IMM_LOAD, 5'h10, 5'h00, 16'h00A5);
    ex(FLE_OP_BIT_TO_T, 5'h00, 5'h10, 16'h0000, 3'h0);
    settle();
    chk(status, 8'h40, "bit one to T");
    ex(FLE_OP_BIT_TO_T, 5'h00, 5'h10, 16'h0000, 3'h1);
    settle();
    chk(status, 8'h00, "bit zero to T");
    ex(FLE_OP_BIT_TO_T, 5'h00, 5'h10, 16'h0000, 3'h2);
    ex(FLE_OP_T_TO_BIT, 5'h11, 5'h11, 16'h0000, 3'h3);
    ex(FLE_OP_REG_COPY, 5'h12, 5'h10);
    ex(FLE_OP_PAIR_COPY, 5'h14, 5'h10);
    for (int i = 0; i < 4; i++) ex(FLE_OP_DIRECT_WRITE, 5'h00, src[i], 16'h0080 + 16'(i));
    settle();
    for (int i = 0; i < 4; i++) chk(u_sram.mem[8'h80 + 8'(i)], exp[i], "moved byte");
    chk(status, 8'h40, "flags kept");
    fl(FLE_OP_FLAG_CLEAR, 3'h6);
    $display("test bits and moves done");
  endtask : t_bits

  task automatic t_ptr();
    logic [7:0]  pv [6] = '{8'h10, 8'h00, 8'h20, 8'h00, 8'h40, 8'h00};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) ex(FLE_OP_IMM_LOAD, 5'h1A + 5'(i), 5'h00, 16'(pv[i]));
    u_sram.mem[8'h10] = 8'h11;
    u_sram.mem[8'h1F] = 8'h22;
    u_sram.mem[8'h45] = 8'h33;
    u_sram.mem[8'h60] = 8'h44;
    ex(FLE_OP_PTR_LOAD, 5'h01, 5'h00, 16'h0000, 3'h0, FLE_PTR_X, FLE_MODE_POST);
    ex(FLE_OP_PTR_LOAD, 5'h02, 5'h00, 16'h0000, 3'h0, FLE_PTR_Y, FLE_MODE_PRE);
    ex(FLE_OP_OFFSET_LOAD, 5'h03, 5'h00, 16'h0005, 3'h0, FLE_PTR_Z);
    ex(FLE_OP_DIRECT_LOAD, 5'h04, 5'h00, 16'h0060);
    ex(FLE_OP_PTR_WRITE, 5'h00, 5'h01, 16'h0000, 3'h0, FLE_PTR_X, FLE_MODE_POST);
    ex(FLE_OP_PTR_WRITE, 5'h00, 5'h02, 16'h0000, 3'h0, FLE_PTR_X, FLE_MODE_POST);
    ex(FLE_OP_PTR_WRITE, 5'h00, 5'h03, 16'h0000, 3'h0, FLE_PTR_Y, FLE_MODE_PRE);
    ex(FLE_OP_DIRECT_WRITE, 5'h00, 5'h04, 16'h0070);
    settle();
    chk(u_sram.mem[8'h11], 8'h11, "post inc");
    chk(u_sram.mem[8'h12], 8'h22, "pre dec load");
    chk(u_sram.mem[8'h1E], 8'h33, "disp load, pre dec store");
    chk(u_sram.mem[8'h70], 8'h44, "direct load");
    rd(12'h004, d, r);
    chk(d[15:0], 16'h0013, "first pointer");
    rd(12'h008, d, r);
    chk(d[15:0], 16'h001E, "second pointer");
    rd(12'h00C, d, r);
    chk(d[15:0], 16'h0040, "third pointer kept");
    chk(status, 8'h00, "mem op flags");
    $display("test pointers done");
  endtask : t_ptr

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_flags();
    t_bits();
    t_ptr();
    test_done();
  end

  // Run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    test_done();
  end
endmodule : fle_exec_bench
`default_nettype wire
